// ===== rtl/aomc_ctrl.sv
// Operating-mode sequencer of an accelerometer.
// Assumes all inputs synchronous to ref_clk; bits arrive as ports.
`timescale 1ns/100ps
`include "aomc_regs.svh"
module aomc_ctrl import aomc_pkg::*; #(
   parameter int BOOT_LOW_CYC  = (`AOMC_BOOT_LOW_NS / `AOMC_CLK_NS),
   parameter int BOOT_HIGH_CYC = (`AOMC_BOOT_HIGH_NS / `AOMC_CLK_NS),
   parameter int HIB_HOLD_CYC  =
      (`AOMC_HIB_HOLD_NS + `AOMC_CLK_NS - 1) / `AOMC_CLK_NS,
   parameter int CNT_W         = 20
) (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic supply_valid,
   input  wire logic boot_strap_select,
   input  wire logic wake_line,
   input  wire logic motion_detect_line,
   input  wire logic event_pin_b_in,
   input  wire logic boot_pulse_enable,
   input  wire logic boot_pulse_to_b,
   input  wire logic active_request,
   input  wire logic hibernate_request,
   input  wire logic pin_b_function_select,
   input  wire logic [7:0] auto_sleep_count,
   input  wire logic activity_seen,
   input  wire logic inactivity_seen,
   output logic      boot_complete_flag,
   output logic      event_pin_a,
   output logic      event_pin_b,
   output logic      event_pin_b_oe,
   output logic      bus_enable,
   output logic      sense_enable,
   output logic      otp_load,
   output logic      otp_motion_load,
   output logic      regs_clear,
   output logic      active_regs_reset,
   output logic      auto_sleep_enable,
   output logic      sleep_mode,
   output logic      measure_busy
);
   localparam int PULSE_LOW_CYC  =
      (`AOMC_PULSE_LOW_NS / `AOMC_CLK_NS) < 1 ? 1 :
      (`AOMC_PULSE_LOW_NS / `AOMC_CLK_NS);
   localparam int PULSE_HIGH_CYC =
      (`AOMC_PULSE_HIGH_NS / `AOMC_CLK_NS) < 1 ? 1 :
      (`AOMC_PULSE_HIGH_NS / `AOMC_CLK_NS);

   aomc_state_type   state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [CNT_W-1:0] pulse_ff, nxt_pulse;
   logic [CNT_W-1:0] hold_ff, nxt_hold;
   logic             pulse_b_ff, nxt_pulse_b;
   logic             wake_ff, nxt_wake;
   logic             trig_ff, nxt_trig;
   logic             strap_ff, nxt_strap;
   logic             flag_ff, nxt_flag;
   logic             asleep_ff, nxt_asleep;
   logic             pin_a_ff, pin_b_ff, b_oe_ff;
   logic             bus_ff, sense_ff, otp_ff, otpm_ff, clr_ff, ars_ff;
   logic             busy_ff, slp_ff;
   logic             nxt_pin_a, nxt_pin_b, nxt_b_oe, nxt_bus, nxt_sense;
   logic             nxt_otp, nxt_otpm, nxt_clr, nxt_ars, nxt_busy, nxt_slp;

   // True while bus access is allowed in a mode
   function automatic logic bus_mode(input aomc_state_type s);
      return (s == ST_STANDBY) || (s == ST_WAKE) || (s == ST_SLEEP) ||
             (s == ST_TRIGWAIT) || (s == ST_MEASURE);
   endfunction

   // Mode sequencer and its counters
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_pulse   = (pulse_ff != '0) ? pulse_ff - 1'b1 : pulse_ff;
      nxt_pulse_b = pulse_b_ff;
      nxt_hold    = motion_detect_line ? '0 :
                    (hold_ff < CNT_W'(HIB_HOLD_CYC)) ? hold_ff + 1'b1
                                                     : hold_ff;
      nxt_wake    = wake_line;
      nxt_trig    = event_pin_b_in;
      nxt_strap   = strap_ff;
      nxt_flag    = flag_ff;
      nxt_asleep  = asleep_ff;
      case (state_ff)
         ST_OFF: begin
            if (supply_valid) begin
               nxt_strap = boot_strap_select; // Strap caught after release
               nxt_state = ST_OTP;
               nxt_cnt   = CNT_W'(`AOMC_OTP_WORDS);
            end
         end
         ST_OTP: begin
            if (cnt_ff == '0) begin
               nxt_state = strap_ff ? ST_OTP_MOT : ST_BOOTWAIT;
               nxt_cnt   = strap_ff ? CNT_W'(`AOMC_OTP_MOT_WORDS)
                                    : CNT_W'(BOOT_LOW_CYC);
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         ST_OTP_MOT: begin
            if (cnt_ff == '0) begin
               nxt_state = ST_BOOTWAIT;
               nxt_cnt   = CNT_W'(BOOT_HIGH_CYC);
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         ST_BOOTWAIT: begin
            if (cnt_ff == '0) begin
               nxt_flag   = 1'b1;
               // Strap high forces pin B; no route to A exists
               nxt_pulse_b = strap_ff | boot_pulse_to_b;
               if (boot_pulse_enable) begin
                  nxt_pulse = strap_ff ? CNT_W'(PULSE_HIGH_CYC)
                                       : CNT_W'(PULSE_LOW_CYC);
               end
               nxt_asleep = ~strap_ff;
               // Strap high goes straight to motion detection
               nxt_state  = strap_ff ? ST_WAKE : ST_STANDBY;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         ST_STANDBY: begin
            if (strap_ff && hold_ff == CNT_W'(HIB_HOLD_CYC)) begin
               nxt_state = ST_HIB;
            end else if (!strap_ff && hibernate_request) begin
               nxt_state = ST_HIB;
            end else if (!strap_ff && pin_b_function_select) begin
               nxt_state = ST_TRIGWAIT;
            end else if (active_request) begin
               nxt_state = ST_WAKE;
            end
         end
         ST_WAKE, ST_SLEEP: begin
            if (strap_ff && hold_ff == CNT_W'(HIB_HOLD_CYC)) begin
               nxt_state = ST_HIB;
            end else if (!active_request && !strap_ff) begin
               nxt_state = ST_STANDBY;
            end else if (auto_sleep_count != 8'h00) begin
               if (state_ff == ST_WAKE && inactivity_seen) begin
                  nxt_state = ST_SLEEP;
               end else if (state_ff == ST_SLEEP && activity_seen) begin
                  nxt_state = ST_WAKE;
               end
            end
         end
         ST_TRIGWAIT: begin
            if (!pin_b_function_select || strap_ff) begin
               nxt_state = ST_STANDBY;
            end else if (event_pin_b_in && !trig_ff) begin
               nxt_state = ST_MEASURE;
               nxt_cnt   = CNT_W'(`AOMC_MEAS_CYCLES);
            end
         end
         ST_MEASURE: begin
            if (cnt_ff == '0) begin
               nxt_state = ST_TRIGWAIT;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         ST_HIB: begin
            nxt_flag = 1'b0;
            if (!strap_ff && (wake_line != wake_ff)) begin
               nxt_state = ST_OTP;
               nxt_cnt   = CNT_W'(`AOMC_OTP_WORDS);
            end else if (strap_ff && motion_detect_line) begin
               nxt_state = ST_OTP;
               nxt_cnt   = CNT_W'(`AOMC_OTP_WORDS);
            end
         end
         default: nxt_state = ST_OFF;
      endcase
      if (!supply_valid) begin
         nxt_state = ST_OFF;
         nxt_flag  = 1'b0;
         // A pulse cut by supply loss must not leak into the next boot
         nxt_pulse = '0;
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_ff   <= ST_OFF;
         cnt_ff     <= '0;
         pulse_ff   <= '0;
         pulse_b_ff <= 1'b0;
         hold_ff    <= '0;
         wake_ff    <= 1'b0;
         trig_ff    <= 1'b0;
         strap_ff   <= 1'b0;
         flag_ff    <= 1'b0;
         asleep_ff  <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         pulse_ff   <= nxt_pulse;
         pulse_b_ff <= nxt_pulse_b;
         hold_ff    <= nxt_hold;
         wake_ff    <= nxt_wake;
         trig_ff    <= nxt_trig;
         strap_ff   <= nxt_strap;
         flag_ff    <= nxt_flag;
         asleep_ff  <= nxt_asleep;
      end
   end

   // Output next values, decoded from the mode being entered (active_regs_reset from the standby-to-wake step); pins A and B from the pulse counter
   always_comb begin
      nxt_pin_a = (nxt_pulse != '0) && !nxt_pulse_b;
      nxt_pin_b = (nxt_pulse != '0) && nxt_pulse_b;
      // Pin B is an input while it serves as the trigger
      nxt_b_oe  = !(nxt_state == ST_TRIGWAIT || nxt_state == ST_MEASURE);
      nxt_bus   = bus_mode(nxt_state);
      nxt_sense = (nxt_state == ST_WAKE) ||
                  (nxt_state == ST_MEASURE);
      nxt_otp   = (nxt_state == ST_OTP);
      nxt_otpm  = (nxt_state == ST_OTP_MOT);
      nxt_clr   = (nxt_state == ST_HIB) || (nxt_state == ST_OFF);
      nxt_ars   = (state_ff == ST_STANDBY) && (nxt_state == ST_WAKE);
      nxt_busy  = (nxt_state == ST_MEASURE);
      nxt_slp   = (nxt_state == ST_SLEEP);
   end

   // Output registers, in step with the mode they describe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_a_ff <= 1'b0;
         pin_b_ff <= 1'b0;
         b_oe_ff  <= 1'b0;
         bus_ff   <= 1'b0;
         sense_ff <= 1'b0;
         otp_ff   <= 1'b0;
         otpm_ff  <= 1'b0;
         clr_ff   <= 1'b0;
         ars_ff   <= 1'b0;
         busy_ff  <= 1'b0;
         slp_ff   <= 1'b0;
      end else begin
         pin_a_ff <= nxt_pin_a;
         pin_b_ff <= nxt_pin_b;
         b_oe_ff  <= nxt_b_oe;
         bus_ff   <= nxt_bus;
         sense_ff <= nxt_sense;
         otp_ff   <= nxt_otp;
         otpm_ff  <= nxt_otpm;
         clr_ff   <= nxt_clr;
         ars_ff   <= nxt_ars;
         busy_ff  <= nxt_busy;
         slp_ff   <= nxt_slp;
      end
   end

   assign boot_complete_flag = flag_ff;
   assign event_pin_a        = pin_a_ff;
   assign event_pin_b        = pin_b_ff;
   assign event_pin_b_oe     = b_oe_ff;
   assign bus_enable         = bus_ff;
   assign sense_enable       = sense_ff;
   assign otp_load           = otp_ff;
   assign otp_motion_load    = otpm_ff;
   assign regs_clear         = clr_ff;
   assign active_regs_reset  = ars_ff;
   assign auto_sleep_enable  = asleep_ff;
   assign sleep_mode         = slp_ff;
   assign measure_busy       = busy_ff;

   // Checks beside the sequencer
   sequence hib_s;
      state_ff == ST_HIB;
   endsequence
   sequence boot_s;
      state_ff == ST_OTP;
   endsequence

   supply_boot_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_ff == ST_OFF && supply_valid |=> boot_s)
      else $error("supply valid did not start boot");
   hib_bus_a: assert property (@(posedge ref_clk) disable iff (reset)
      hib_s ##1 hib_s |-> !bus_enable && !sense_enable)
      else $error("bus active in hibernate");
   hib_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
      hib_s |-> regs_clear)
      else $error("registers not cleared in hibernate");
   wake_edge_a: assert property (@(posedge ref_clk) disable iff (reset)
      hib_s and (!strap_ff && wake_line != wake_ff && supply_valid)
      |=> boot_s)
      else $error("wake edge ignored");
   motion_wake_a: assert property (@(posedge ref_clk) disable iff (reset)
      hib_s and (strap_ff && motion_detect_line && supply_valid)
      |=> boot_s)
      else $error("motion line did not wake");
   strap_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
      strap_ff |-> !event_pin_a)
      else $error("boot pulse on pin A with strap high");
   trig_meas_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_ff == ST_TRIGWAIT && supply_valid && pin_b_function_select &&
      !strap_ff && event_pin_b_in && !trig_ff |=> state_ff == ST_MEASURE)
      else $error("trigger edge missed");
   meas_back_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_ff == ST_MEASURE && cnt_ff == '0 && supply_valid
      |=> state_ff == ST_TRIGWAIT)
      else $error("no return to trigger wait");
   boot_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_ff == ST_BOOTWAIT && cnt_ff == '0 && supply_valid
      |=> boot_complete_flag && bus_enable)
      else $error("boot flag not set");
   hib_req_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_ff == ST_STANDBY && !strap_ff && hibernate_request &&
      supply_valid |=> hib_s)
      else $error("hibernate request ignored");
   motion_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == ST_WAKE || state_ff == ST_SLEEP) && strap_ff &&
      hold_ff == CNT_W'(HIB_HOLD_CYC) && supply_valid |=> hib_s)
      else $error("motion hold did not enter hibernate");
   hib_stay_a: assert property (@(posedge ref_clk) disable iff (reset)
      hib_s and (strap_ff && !motion_detect_line && supply_valid)
      |=> hib_s)
      else $error("hibernate left with motion line low");
   standby_bus_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_ff == ST_STANDBY |-> bus_enable && !sense_enable)
      else $error("standby bus or sensing wrong");
   boot_bus_a: assert property (@(posedge ref_clk) disable iff (reset)
      state_ff == ST_OTP || state_ff == ST_OTP_MOT ||
      state_ff == ST_BOOTWAIT |-> !bus_enable && !boot_complete_flag)
      else $error("bus open before boot complete");
endmodule

// ===== rtl/aomc_regs.svh
// Constants for the accelerometer operating-mode controller.
// Assumes a 25 MHz ref_clk; boot waits are parameters of the top.
//
// Function
// - Supply-valid starts the boot sequence
// - Strap low: load defaults, flag, pulse
// - Strap low: pulse on pin A, optionally B
// - Strap high: also load motion parameters
// - Strap high: pulse only on pin B
// - Hibernate: only wake logic, bus off
// - Hibernate discards host register values
// - Strap low: wake-line edge wakes hibernate
// - Strap high: motion line high wakes, detects
// - Strap high: bus only after boot
// - Standby: sensing off, bus available
// - Active: sensing power-cycled, bus available
// - Auto-sleep count nonzero enables wake/sleep
// - Strap high: auto wake/sleep default off
// - Pin B rising edge starts measurement
// - After measurement return to trigger wait
// - Active to standby keeps registers
// - Strap low: hibernate request enters hibernate
// - Strap high: motion low hold enters hibernate
`ifndef AOMC_REGS_SVH
`define AOMC_REGS_SVH
`define AOMC_CLK_NS          40
`define AOMC_BOOT_LOW_NS     1000000
`define AOMC_BOOT_HIGH_NS    1000000
`define AOMC_PULSE_LOW_NS    1000
`define AOMC_PULSE_HIGH_NS   1000
`define AOMC_HIB_HOLD_NS     1000000
`define AOMC_OTP_WORDS       4
`define AOMC_OTP_MOT_WORDS   4
`define AOMC_MEAS_CYCLES     16
`endif

// ===== rtl/aomc_pkg.sv
// Types of the operating-mode controller.
// Assumes no other package is needed.
package aomc_pkg;
   typedef enum logic [3:0] {
      ST_OFF      = 4'h0,
      ST_OTP      = 4'h1,
      ST_OTP_MOT  = 4'h2,
      ST_BOOTWAIT = 4'h3,
      ST_STANDBY  = 4'h4,
      ST_WAKE     = 4'h5,
      ST_SLEEP    = 4'h6,
      ST_TRIGWAIT = 4'h7,
      ST_MEASURE  = 4'h8,
      ST_HIB      = 4'h9
   } aomc_state_type;
endpackage

// ===== testbench/aomc_host_model.sv
// Host microcontroller model driving the mode pins of the controller.
// Assumes the bench calls its tasks; pins change only after rising edges.
`timescale 1ns/100ps
module aomc_host_model #(
   parameter int BOOT_CYC = 10,
   parameter int HOLD_CYC = 10
) (
   input  wire logic ref_clk,
   output logic      wake_line,
   output logic      motion_detect_line,
   output logic      host_pin_b,
   output logic      pin_b_function_select
);
   // Idle levels: wake high, motion low
   initial begin
      wake_line = 1'b1;
      motion_detect_line = 1'b0;
      host_pin_b = 1'b0;
      pin_b_function_select = 1'b0;
   end
   // Either edge wakes; bus stays untouched until boot is over
   task automatic toggle_wake();
      @(posedge ref_clk);
      wake_line <= ~wake_line;
      repeat (BOOT_CYC + 12) @(posedge ref_clk);
   endtask
   task automatic raise_motion();
      @(posedge ref_clk);
      motion_detect_line <= 1'b1;
   endtask
   // Held low past the entry time, and kept low
   task automatic hold_motion_low();
      @(posedge ref_clk);
      motion_detect_line <= 1'b0;
      repeat (HOLD_CYC + 2) @(posedge ref_clk);
   endtask
   // Trigger mode only exists with the strap low
   task automatic set_trig(input logic on, input logic strap_high);
      @(posedge ref_clk);
      pin_b_function_select <= on & ~strap_high;
   endtask
   // One clean low-to-high edge, then back low
   task automatic trigger();
      @(posedge ref_clk);
      host_pin_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      host_pin_b <= 1'b0;
   endtask
endmodule

// ===== testbench/test_aomc_ctrl.sv
// Self-checking bench of the operating-mode controller.
// Assumes the host model file; short boot and hold counts of 10.
`timescale 1ns/100ps
module test_aomc_ctrl;
   import aomc_pkg::*;
   logic       ref_clk = 1'b0, reset = 1'b1, supply_valid = 1'b0;
   logic       strap = 1'b0, pulse_en = 1'b0, pulse_b = 1'b0;
   logic       act_req = 1'b0, hib_req = 1'b0;
   logic       act_seen = 1'b0, inact_seen = 1'b0;
   logic [7:0] asc = 8'h00;
   logic       wake, motion, host_b, fsel, pin_b;
   logic       flag, pa, pb, pb_oe, bus_enable, sense, otp, otp_mot;
   logic       regs_clear, ars, ase, sleep_mode, busy;
   logic       seen_otp, seen_mot, seen_pa, seen_pb, seen_ars;
   int         fail_count = 0, num_checks = 0;
   // Shared pin B: the controller wins only while it enables its driver
   assign pin_b = pb_oe ? pb : host_b;
   aomc_ctrl #(.BOOT_LOW_CYC(10), .BOOT_HIGH_CYC(10), .HIB_HOLD_CYC(10)) dut (
      .ref_clk(ref_clk), .reset(reset), .supply_valid(supply_valid),
      .boot_strap_select(strap), .wake_line(wake),
      .motion_detect_line(motion), .event_pin_b_in(pin_b),
      .boot_pulse_enable(pulse_en), .boot_pulse_to_b(pulse_b),
      .active_request(act_req), .hibernate_request(hib_req),
      .pin_b_function_select(fsel), .auto_sleep_count(asc),
      .activity_seen(act_seen), .inactivity_seen(inact_seen),
      .boot_complete_flag(flag), .event_pin_a(pa), .event_pin_b(pb),
      .event_pin_b_oe(pb_oe), .bus_enable(bus_enable), .sense_enable(sense),
      .otp_load(otp), .otp_motion_load(otp_mot), .regs_clear(regs_clear),
      .active_regs_reset(ars), .auto_sleep_enable(ase),
      .sleep_mode(sleep_mode), .measure_busy(busy));
   aomc_host_model #(.BOOT_CYC(10), .HOLD_CYC(10)) host (
      .ref_clk(ref_clk), .wake_line(wake), .motion_detect_line(motion),
      .host_pin_b(host_b), .pin_b_function_select(fsel));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   // Sticky event catchers, read at negedge so every pulse is seen
   always @(negedge ref_clk) begin
      seen_otp |= otp;
      seen_mot |= otp_mot;
      seen_pa |= pa;
      seen_pb |= pb;
      seen_ars |= ars;
   end
   task automatic clr();
      {seen_otp, seen_mot, seen_pa, seen_pb, seen_ars} = 5'h00;
   endtask
   task automatic chk(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait: 0 bus, 1 flag, 2 busy, other sleep
   task automatic wait_on(input int sel, input logic want);
      logic v;
      int   n;
      v = ~want;
      for (n = 0; n < 200 && v !== want; n++) begin
         @(negedge ref_clk);
         case (sel)
            0: v = bus_enable;
            1: v = flag;
            2: v = busy;
            default: v = sleep_mode;
         endcase
      end
      chk(v, want);
   endtask
   task automatic pulse_sense(input logic inact);
      @(posedge ref_clk);
      inact_seen <= inact;
      act_seen <= ~inact;
      @(posedge ref_clk);
      {inact_seen, act_seen} <= 2'h0;
   endtask
   task automatic boot_low();
      clr();
      @(posedge ref_clk);
      pulse_en <= 1'b1;
      supply_valid <= 1'b1;
      // One OFF cycle, five OTP cycles, eleven boot-wait cycles
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(flag, 1'b0);
      @(negedge ref_clk);
      chk(flag, 1'b1);
      wait_on(1, 1'b1);
      chk(seen_otp, 1'b1);
      chk(seen_mot, 1'b0);
      wait_on(0, 1'b1);
      chk(sense, 1'b0);
      chk(seen_pa, 1'b1);
      chk(seen_pb, 1'b0);
   endtask
   task automatic active_sleep();
      clr();
      @(posedge ref_clk);
      asc <= 8'h01;
      act_req <= 1'b1;
      pulse_sense(1'b1);
      wait_on(3, 1'b1);
      pulse_sense(1'b0);
      wait_on(3, 1'b0);
      chk(sense, 1'b1);
      chk(seen_ars, 1'b1);
      chk(bus_enable, 1'b1);
      @(posedge ref_clk);
      act_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(regs_clear, 1'b0);
      chk(sense, 1'b0);
   endtask
   task automatic trigger_cycle();
      host.set_trig(1'b1, 1'b0);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(pb_oe, 1'b0);
      host.trigger();
      wait_on(2, 1'b1);
      wait_on(2, 1'b0);
      host.trigger();
      wait_on(2, 1'b1);
      wait_on(2, 1'b0);
      host.set_trig(1'b0, 1'b0);
   endtask
   task automatic hibernate_low();
      @(posedge ref_clk);
      hib_req <= 1'b1;
      wait_on(0, 1'b0);
      chk(regs_clear, 1'b1);
      chk(sense, 1'b0);
      @(posedge ref_clk);
      hib_req <= 1'b0;
      pulse_b <= 1'b1;
      clr();
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(bus_enable, 1'b0);
      host.toggle_wake();
      wait_on(0, 1'b1);
      chk(regs_clear, 1'b0);
      chk(seen_pb, 1'b1);
      chk(seen_pa, 1'b0);
   endtask
   task automatic boot_high();
      @(posedge ref_clk);
      supply_valid <= 1'b0;
      strap <= 1'b1;
      pulse_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(bus_enable, 1'b0);
      clr();
      host.raise_motion();
      supply_valid <= 1'b1;
      // Loading motion parameters: bus and flag must stay low
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(bus_enable, 1'b0);
      chk(flag, 1'b0);
      wait_on(1, 1'b1);
      chk(bus_enable, 1'b1);
      wait_on(0, 1'b1);
      chk(sense, 1'b1);
      chk(seen_mot, 1'b1);
      chk(seen_pa, 1'b0);
      chk(seen_pb, 1'b1);
      chk(ase, 1'b0);
      host.set_trig(1'b1, 1'b1);
      host.hold_motion_low();
      wait_on(0, 1'b0);
      chk(regs_clear, 1'b1);
   endtask
   task automatic close_out();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog at 20000 cycles; the whole sequence needs well under a thousand
   initial begin
      #(40 * 20000);
      fail_count++;
      close_out();
   end
   initial begin
      clr();
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      chk(bus_enable, 1'b0);
      boot_low();
      active_sleep();
      trigger_cycle();
      hibernate_low();
      boot_high();
      close_out();
   end
endmodule
